// File: hw/sdc_regs.sv
// Control register bank of a stepper driver: settings, step/dir source,
// lock, fault clear and protection policy.
// Assumes a register port from an SPI framer on clk; pins are asynchronous.
// Operation
// - torque scale bits 7-4, 16 levels
// - edge-rate bits 1-0 select four slopes
// - disable bit or drive-off pin tristates outputs
// - off-time bits 4-3, reset 01
// - decay field decodes fixed and adaptive modes
// - direction from register when source bit set
// - register step bit advances one step
// - source bits choose pin or register
// - step resolution field bits 3-0 reset 0
// - register step bit self-clears
// - fault clear bit clears flags, self-clears
// - writing 110 locks other registers
// - only 011 unlocks; lock resets unlocked
// - open-load detection only when enabled
// - overcurrent latched or auto-retry
// - thermal shutdown latched or auto-recover
// - temperature warnings on fault pin if enabled
// - undervoltage flags set at power-up until cleared
// - first control register at address 0x03
`timescale 1ns/1ps
`default_nettype none
module sdc_regs
  import sdc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Register port
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [5:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  // Pins
  input  wire logic       drive_off_pin,
  input  wire logic       dir_pin,
  input  wire logic       step_pin,
  // Protection events
  input  wire logic       overcurrent_event,
  input  wire logic       overtemp_event,
  input  wire logic       temp_warning_event,
  // Outputs to the drive
  output logic            outputs_hiz,
  output logic            dir_out,
  output logic            step_pulse,
  output logic            fault_clear_pulse,
  output logic            open_load_enable,
  output logic            overcurrent_response,
  output logic            thermal_shutdown_response,
  output logic            uv_flag,
  output logic            cpuv_flag,
  output logic            fault_pin_n,
  output var sdc_drive_cfg_t drive_cfg
);
  sdc_state_t st, next_st;
  logic [2:0] sync_a, sync_b;
  logic       step_pin_d;
  logic       ocp_latched, ots_latched;
  logic       next_ocp, next_ots;
  sdc_drive_cfg_t cfg_c;
  logic       wr_unlocked;
  logic [2:0] pins_s;

  // Two-stage synchroniser for the three pins; stage b alone is read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_a     <= 3'h0;
      sync_b     <= 3'h0;
      step_pin_d <= 1'b0;
    end else begin
      sync_a     <= {drive_off_pin, dir_pin, step_pin};
      sync_b     <= sync_a;
      step_pin_d <= sync_b[0];
    end
  end
  assign pins_s = sync_b;

  // Writes allowed to ordinary registers only while unlocked
  assign wr_unlocked = reg_wr && !st.locked;

  // Next-state logic for the whole bank
  always_comb begin
    next_st = st;
    next_st.step_pulse        = 1'b0;
    next_st.fault_clear_pulse = 1'b0;
    next_st.step[STP_BIT]     = 1'b0;
    next_st.prot[CLR_BIT]     = 1'b0;
    if (wr_unlocked) begin
      case (reg_addr)
        ADDR_TORQUE: next_st.torque = reg_wdata;
        ADDR_DECAY:  next_st.decay  = reg_wdata;
        ADDR_STEP: begin
          // Resolution field stored as written; reserved codes are kept out by the host
          next_st.step = reg_wdata;
          next_st.step[STP_BIT] = 1'b0;
          // Register step fires once per written one
          next_st.step_pulse = reg_wdata[STP_BIT] & reg_wdata[SSRC_BIT];
        end
        ADDR_RSV_A: next_st.rsv_a = reg_wdata;
        ADDR_RSV_B: next_st.rsv_b = reg_wdata;
        default: ;
      endcase
    end
    // Protection register stays writable in its low bits only when unlocked
    if (reg_wr && reg_addr == ADDR_PROT) begin
      if (!st.locked) begin
        next_st.prot[OL_BIT:TWR_BIT] = reg_wdata[OL_BIT:TWR_BIT];
        if (reg_wdata[LCK_HI:LCK_LO] == LOCK_CODE) begin
          next_st.locked = 1'b1;
          next_st.prot[LCK_HI:LCK_LO] = LOCK_CODE;
        end
      end else if (reg_wdata[LCK_HI:LCK_LO] == UNLOCK_CODE) begin
        next_st.locked = 1'b0;
        next_st.prot[LCK_HI:LCK_LO] = UNLOCK_CODE;
      end
      next_st.fault_clear_pulse = reg_wdata[CLR_BIT];
    end
    // Output disable or pin forces high impedance
    next_st.outputs_hiz = st.decay[DIS_BIT] | pins_s[2];
    // Direction source select
    next_st.dir_out = st.step[DSRC_BIT] ? st.step[DIR_BIT] : pins_s[1];
    // Pin step passes through on a rising edge when pin source chosen
    if (!st.step[SSRC_BIT] && pins_s[0] && !step_pin_d) begin
      next_st.step_pulse = 1'b1;
    end
    // Undervoltage flags hold until cleared
    if (next_st.fault_clear_pulse) begin
      next_st.uv_flag   = 1'b0;
      next_st.cpuv_flag = 1'b0;
    end
    // Read data, sampled on the read strobe; the lock never blocks reads
    if (reg_rd) begin
      case (reg_addr)
        ADDR_TORQUE: next_st.rdata = st.torque;
        ADDR_DECAY:  next_st.rdata = st.decay;
        ADDR_STEP:   next_st.rdata = st.step;
        ADDR_PROT:   next_st.rdata = st.prot;
        ADDR_RSV_A:  next_st.rdata = st.rsv_a;
        ADDR_RSV_B:  next_st.rdata = st.rsv_b;
        default:     next_st.rdata = 8'h00;
      endcase
    end
    // Fault pin: latched faults, undervoltage, optional warnings
    next_st.fault_n = !(ocp_latched | ots_latched | st.uv_flag | st.cpuv_flag
                        | (st.prot[TWR_BIT] & temp_warning_event));
  end

  // Fault latches follow the response policy; events beat clears
  always_comb begin
    next_ocp = ocp_latched;
    next_ots = ots_latched;
    if (st.fault_clear_pulse) begin
      next_ocp = 1'b0;
      next_ots = 1'b0;
    end
    if (st.prot[OCP_BIT]) next_ocp = overcurrent_event;
    else if (overcurrent_event) next_ocp = 1'b1;
    if (st.prot[OTS_BIT]) next_ots = overtemp_event;
    else if (overtemp_event) next_ots = 1'b1;
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st          <= '0;
      st.torque   <= RST_TORQUE;
      st.decay    <= RST_DECAY;
      st.step     <= RST_STEP;
      st.prot     <= RST_PROT;
      st.rsv_a    <= RST_RSV_A;
      st.rsv_b    <= RST_RSV_B;
      st.fault_n  <= 1'b1;
      st.uv_flag  <= 1'b1;
      st.cpuv_flag <= 1'b1;
      ocp_latched <= 1'b0;
      ots_latched <= 1'b0;
      drive_cfg   <= '0;
    end else begin
      st          <= next_st;
      ocp_latched <= next_ocp;
      ots_latched <= next_ots;
      drive_cfg   <= cfg_c;
    end
  end

  // Table decode of the setting fields
  sdc_decode u_decode (
    .torque_scale (st.torque[TRQ_HI:TRQ_LO]),
    .edge_sel     (st.torque[EDGE_HI:EDGE_LO]),
    .off_time_sel (st.decay[OFF_HI:OFF_LO]),
    .decay_sel    (st.decay[DEC_HI:DEC_LO]),
    .cfg          (cfg_c)
  );

  // Outputs straight from the state flops
  assign reg_rdata                 = st.rdata;
  assign outputs_hiz               = st.outputs_hiz;
  assign dir_out                   = st.dir_out;
  assign step_pulse                = st.step_pulse;
  assign fault_clear_pulse         = st.fault_clear_pulse;
  assign open_load_enable          = st.prot[OL_BIT];
  assign overcurrent_response      = st.prot[OCP_BIT];
  assign thermal_shutdown_response = st.prot[OTS_BIT];
  assign uv_flag                   = st.uv_flag;
  assign cpuv_flag                 = st.cpuv_flag;
  assign fault_pin_n               = st.fault_n;

  // Checks
  a_lock_holds: assert property (@(posedge clk) disable iff (!reset_n)
    st.locked && reg_wr && reg_addr == ADDR_TORQUE |=> $stable(st.torque))
    else $error("torque changed while locked");
  a_lock_sets: assert property (@(posedge clk) disable iff (!reset_n)
    !st.locked && reg_wr && reg_addr == ADDR_PROT && reg_wdata[6:4] == 3'h6 |=> st.locked)
    else $error("lock code did not lock");
  a_unlock_only: assert property (@(posedge clk) disable iff (!reset_n)
    st.locked && reg_wr && reg_addr == ADDR_PROT && reg_wdata[6:4] != 3'h3 |=> st.locked)
    else $error("wrong code unlocked");
  a_step_once: assert property (@(posedge clk) disable iff (!reset_n)
    wr_unlocked && reg_addr == ADDR_STEP && reg_wdata[6] && reg_wdata[4]
    |=> step_pulse ##1 !st.step[6])
    else $error("register step not single");
  a_clr_self: assert property (@(posedge clk) disable iff (!reset_n)
    reg_wr && reg_addr == ADDR_PROT && reg_wdata[7] |=> fault_clear_pulse && !st.prot[7])
    else $error("fault clear not self clearing");
  a_hiz_follow: assert property (@(posedge clk) disable iff (!reset_n)
    st.decay[7] |=> outputs_hiz)
    else $error("disable did not tristate");
  a_dir_reg: assert property (@(posedge clk) disable iff (!reset_n)
    st.step[5] |=> dir_out == $past(st.step[7]))
    else $error("direction not from register");
  a_uv_clear: assert property (@(posedge clk) disable iff (!reset_n)
    fault_clear_pulse |=> !uv_flag && !cpuv_flag)
    else $error("undervoltage flags not cleared");

  // Register writes, torque read-back and the lock filter
  a_torque_write: assert property (@(posedge clk) disable iff (!reset_n)
    !st.locked && reg_wr && reg_addr == ADDR_TORQUE |=> st.torque == $past(reg_wdata))
    else $error("torque write not stored");
  a_decay_locked: assert property (@(posedge clk) disable iff (!reset_n)
    st.locked && reg_wr && reg_addr == ADDR_DECAY |=> $stable(st.decay))
    else $error("decay changed while locked");
  a_step_locked: assert property (@(posedge clk) disable iff (!reset_n)
    st.locked && reg_wr && reg_addr == ADDR_STEP |=> $stable(st.step))
    else $error("step register changed while locked");
  a_prot_locked: assert property (@(posedge clk) disable iff (!reset_n)
    st.locked && reg_wr && reg_addr == ADDR_PROT |=> st.prot[3:0] == $past(st.prot[3:0]))
    else $error("protection bits changed while locked");
  a_unlock_opens: assert property (@(posedge clk) disable iff (!reset_n)
    st.locked && reg_wr && reg_addr == ADDR_PROT && reg_wdata[6:4] == 3'h3 |=> !st.locked)
    else $error("unlock code did not unlock");
  a_lock_ignore: assert property (@(posedge clk) disable iff (!reset_n)
    !st.locked && reg_wr && reg_addr == ADDR_PROT && reg_wdata[6:4] != 3'h6 |=> !st.locked)
    else $error("wrong code locked");
  a_read_torque: assert property (@(posedge clk) disable iff (!reset_n)
    reg_rd && reg_addr == ADDR_TORQUE |=> reg_rdata == $past(st.torque))
    else $error("torque read data wrong");

  // Self-clearing command bits never read back as one
  a_step_bit_low: assert property (@(posedge clk) disable iff (!reset_n)
    !st.step[STP_BIT])
    else $error("step bit stuck");
  a_clr_bit_low: assert property (@(posedge clk) disable iff (!reset_n)
    !st.prot[CLR_BIT])
    else $error("fault clear bit stuck");

  // Pin paths: the synchronised pin drives the outputs one edge later
  a_pin_hiz: assert property (@(posedge clk) disable iff (!reset_n)
    pins_s[2] |=> outputs_hiz)
    else $error("drive-off pin did not tristate");
  a_hiz_release: assert property (@(posedge clk) disable iff (!reset_n)
    !st.decay[7] && !pins_s[2] |=> !outputs_hiz)
    else $error("outputs stayed tristated");
  a_dir_pin: assert property (@(posedge clk) disable iff (!reset_n)
    !st.step[5] |=> dir_out == $past(pins_s[1]))
    else $error("direction not from pin");

  // Protection policy; a set event always beats a clear
  a_ocp_latch: assert property (@(posedge clk) disable iff (!reset_n)
    !st.prot[2] && overcurrent_event |=> ocp_latched)
    else $error("overcurrent not latched");
  a_ocp_retry: assert property (@(posedge clk) disable iff (!reset_n)
    st.prot[2] |=> ocp_latched == $past(overcurrent_event))
    else $error("overcurrent retry wrong");
  a_ots_recover: assert property (@(posedge clk) disable iff (!reset_n)
    st.prot[1] |=> ots_latched == $past(overtemp_event))
    else $error("thermal recovery wrong");
  a_warn_masked: assert property (@(posedge clk) disable iff (!reset_n)
    !st.prot[0] && !ocp_latched && !ots_latched && !st.uv_flag && !st.cpuv_flag
    |=> fault_pin_n)
    else $error("masked warning reached fault pin");
endmodule : sdc_regs
`default_nettype wire

// File: hw/sdc_pkg.sv
// Package for the stepper driver control register bank.
// Assumes an internal register port (address, write strobe, data) from an SPI framer.
package sdc_pkg;
  // Register addresses
  localparam logic [5:0] ADDR_TORQUE = 6'h03;
  localparam logic [5:0] ADDR_DECAY  = 6'h04;
  localparam logic [5:0] ADDR_STEP   = 6'h05;
  localparam logic [5:0] ADDR_PROT   = 6'h06;
  localparam logic [5:0] ADDR_RSV_A  = 6'h07;
  localparam logic [5:0] ADDR_RSV_B  = 6'h08;
  // Reset values
  localparam logic [7:0] RST_TORQUE = 8'h00;
  localparam logic [7:0] RST_DECAY  = 8'h0f;
  localparam logic [7:0] RST_STEP   = 8'h00;
  localparam logic [7:0] RST_PROT   = 8'h30;
  localparam logic [7:0] RST_RSV_A  = 8'h08;
  localparam logic [7:0] RST_RSV_B  = 8'h0f;
  // Field positions
  localparam int TRQ_HI = 7;
  localparam int TRQ_LO = 4;
  localparam int EDGE_HI = 1;
  localparam int EDGE_LO = 0;
  localparam int DIS_BIT = 7;
  localparam int OFF_HI = 4;
  localparam int OFF_LO = 3;
  localparam int DEC_HI = 2;
  localparam int DEC_LO = 0;
  localparam int DIR_BIT = 7;
  localparam int STP_BIT = 6;
  localparam int DSRC_BIT = 5;
  localparam int SSRC_BIT = 4;
  localparam int RES_HI = 3;
  localparam int RES_LO = 0;
  localparam int CLR_BIT = 7;
  localparam int LCK_HI = 6;
  localparam int LCK_LO = 4;
  localparam int OL_BIT = 3;
  localparam int OCP_BIT = 2;
  localparam int OTS_BIT = 1;
  localparam int TWR_BIT = 0;
  // Lock codes
  localparam logic [2:0] LOCK_CODE   = 3'h6;
  localparam logic [2:0] UNLOCK_CODE = 3'h3;
  // Off-time in microseconds per code, and cycles at 125 MHz
  localparam int CLK_MHZ = 125;
  localparam int OFF_US0 = 7;
  localparam int OFF_US1 = 16;
  localparam int OFF_US2 = 24;
  localparam int OFF_US3 = 32;
  localparam logic [12:0] OFF_CYC0 = 13'(OFF_US0 * CLK_MHZ);
  localparam logic [12:0] OFF_CYC1 = 13'(OFF_US1 * CLK_MHZ);
  localparam logic [12:0] OFF_CYC2 = 13'(OFF_US2 * CLK_MHZ);
  localparam logic [12:0] OFF_CYC3 = 13'(OFF_US3 * CLK_MHZ);
  // Decay codes
  typedef enum logic [1:0] {DK_SLOW = 2'h0, DK_MIX30 = 2'h1, DK_MIX60 = 2'h2,
                            DK_FAST = 2'h3} sdc_decay_t;
  // Decoded settings handed to the drive logic
  typedef struct packed {
    logic [7:0]  torque_pct_x16; // Scale in 1/16 steps, 16 = full
    logic [6:0]  edge_v_per_us;
    logic [12:0] off_cycles;
    sdc_decay_t  decay_rise;
    sdc_decay_t  decay_fall;
    logic        adaptive;
    logic        adaptive_ripple;
  } sdc_drive_cfg_t;
  // Register bank state
  typedef struct packed {
    logic [7:0] torque;
    logic [7:0] decay;
    logic [7:0] step;
    logic [7:0] prot;
    logic [7:0] rsv_a;
    logic [7:0] rsv_b;
    logic       locked;
    logic [7:0] rdata;
    logic       outputs_hiz;
    logic       dir_out;
    logic       step_pulse;
    logic       fault_clear_pulse;
    logic       uv_flag;
    logic       cpuv_flag;
    logic       fault_n;
  } sdc_state_t;
  // Lock filter state
  typedef enum logic [1:0] {LK_OPEN = 2'b00, LK_SHUT = 2'b01} sdc_lock_t;
endpackage : sdc_pkg

// File: hw/sdc_decode.sv
// Decoder from raw register fields to drive settings.
// Assumes registered inputs from the register bank on the same clock.
`timescale 1ns/1ps
`default_nettype none
module sdc_decode
  import sdc_pkg::*;
(
  // Raw fields
  input  wire logic [3:0] torque_scale,
  input  wire logic [1:0] edge_sel,
  input  wire logic [1:0] off_time_sel,
  input  wire logic [2:0] decay_sel,
  // Decoded settings
  output var sdc_drive_cfg_t cfg
);
  // Pure table lookups; no state here
  always_comb begin
    cfg = '0;
    cfg.torque_pct_x16 = 8'(5'h10 - {1'b0, torque_scale});
    case (edge_sel)
      2'h0:    cfg.edge_v_per_us = 7'd10;
      2'h1:    cfg.edge_v_per_us = 7'd35;
      2'h2:    cfg.edge_v_per_us = 7'd50;
      default: cfg.edge_v_per_us = 7'd105;
    endcase
    case (off_time_sel)
      2'h0:    cfg.off_cycles = OFF_CYC0;
      2'h1:    cfg.off_cycles = OFF_CYC1;
      2'h2:    cfg.off_cycles = OFF_CYC2;
      default: cfg.off_cycles = OFF_CYC3;
    endcase
    case (decay_sel)
      3'h0: begin cfg.decay_rise = DK_SLOW; cfg.decay_fall = DK_SLOW; end
      3'h1: begin cfg.decay_rise = DK_SLOW; cfg.decay_fall = DK_MIX30; end
      3'h2: begin cfg.decay_rise = DK_SLOW; cfg.decay_fall = DK_MIX60; end
      3'h3: begin cfg.decay_rise = DK_SLOW; cfg.decay_fall = DK_FAST; end
      3'h4: begin cfg.decay_rise = DK_MIX30; cfg.decay_fall = DK_MIX30; end
      3'h5: begin cfg.decay_rise = DK_MIX60; cfg.decay_fall = DK_MIX60; end
      3'h6: cfg.adaptive = 1'b1;
      default: begin
        cfg.adaptive = 1'b1;
        cfg.adaptive_ripple = 1'b1;
      end
    endcase
  end
endmodule : sdc_decode
`default_nettype wire

// File: tb/sdc_host_model.sv
// Host model: issues single-byte register requests the way the SPI framer
// hands them to the bank. Assumes clk from the testbench.
`timescale 1ns/1ps
`default_nettype none
module sdc_host_model
  import sdc_pkg::*;
(
  // Clock
  input  wire logic       clk,
  // Register port
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [5:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // Idle bus at time zero
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 6'h3f;
    reg_wdata = 8'h00;
  end

  // One request held across one taking edge; released address and data lines show the
  // inverse of the last value so a stale sample cannot pass by luck
  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clk);
    #1;
    reg_wr    = w;
    reg_rd    = ~w;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    q         = reg_rdata;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : xfer

  // Write; reserved encodings never leave the host
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    if (a == ADDR_STEP && d[3:0] > 4'ha) d[3:0] = 4'ha;
    if (a == ADDR_RSV_A) d = RST_RSV_A;
    xfer(1'b1, a, d, q);
  endtask : wr

  // Read
  task automatic rd(input logic [5:0] a, output logic [7:0] q);
    xfer(1'b0, a, 8'h00, q);
  endtask : rd
endmodule : sdc_host_model
`default_nettype wire

// File: tb/sdc_regs_tb.sv
// Testbench for the stepper driver control register bank.
// Assumes the host model owns the register port; pins and events come from here.
`timescale 1ns/1ps
`default_nettype none
module sdc_regs_tb;
  import sdc_pkg::*;
  // Clock, reset and design signals
  logic           clk = 1'b0;
  logic           reset_n = 1'b0;
  logic           reg_wr, reg_rd;
  logic [5:0]     reg_addr;
  logic [7:0]     reg_wdata, reg_rdata, q;
  logic           drive_off_pin, dir_pin, step_pin;
  logic           overcurrent_event, overtemp_event, temp_warning_event;
  logic           outputs_hiz, dir_out, step_pulse, fault_clear_pulse;
  logic           open_load_enable, overcurrent_response, thermal_shutdown_response;
  logic           uv_flag, cpuv_flag, fault_pin_n;
  sdc_drive_cfg_t drive_cfg;
  int             err_total = 0, checks_done = 0, n_step = 0, n_clr = 0;

  always #4 clk = ~clk;

  // Pulses stand one cycle, so they are counted at every edge
  always @(posedge clk) begin
    if (step_pulse === 1'b1) n_step++;
    if (fault_clear_pulse === 1'b1) n_clr++;
  end

  sdc_regs DUT (.clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .drive_off_pin, .dir_pin, .step_pin, .overcurrent_event, .overtemp_event,
    .temp_warning_event, .outputs_hiz, .dir_out, .step_pulse, .fault_clear_pulse,
    .open_load_enable, .overcurrent_response, .thermal_shutdown_response, .uv_flag,
    .cpuv_flag, .fault_pin_n, .drive_cfg);
  sdc_host_model HOST (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    HOST.rd(a, q);
    chk(16'(q), 16'(e));
  endtask : rchk

  // Reset values of every register and flag
  task automatic t_reset;
    rchk(6'h03, 8'h00);
    rchk(ADDR_DECAY, 8'h0f);
    rchk(ADDR_STEP, 8'h00);
    rchk(ADDR_PROT, 8'h30);
    rchk(ADDR_RSV_A, 8'h08);
    rchk(ADDR_RSV_B, 8'h0f);
    rchk(6'h09, 8'h00);
    chk(16'({uv_flag, cpuv_flag, fault_pin_n}), 16'h0006);
    chk(16'({open_load_enable, overcurrent_response, thermal_shutdown_response}), 16'h0);
  endtask : t_reset

  // Every torque, edge, off-time and decay code, read back and decoded
  task automatic t_fields;
    int e_edge[4] = '{10, 35, 50, 105};
    int e_off[4] = '{7, 16, 24, 32};
    int e_dec[6] = '{'h0, 'h1, 'h2, 'h3, 'h5, 'ha};
    for (int i = 0; i < 16; i++) begin
      HOST.wr(ADDR_TORQUE, {i[3:0], 2'b00, i[1:0]});
      HOST.wr(ADDR_DECAY, {3'b000, i[1:0], i[2:0]});
      rchk(ADDR_TORQUE, {i[3:0], 2'b00, i[1:0]});
      rchk(ADDR_DECAY, {3'b000, i[1:0], i[2:0]});
      chk(16'(drive_cfg.torque_pct_x16), 16'(16 - i));
      chk(16'(drive_cfg.edge_v_per_us), 16'(e_edge[i % 4]));
      chk(16'(drive_cfg.off_cycles), 16'(e_off[i % 4] * 125));
      chk(16'({drive_cfg.adaptive | drive_cfg.adaptive_ripple, drive_cfg.adaptive_ripple}),
          16'({i[2:0] > 3'h5, i[2:0] == 3'h7}));
      if (i[2:0] < 3'h6) chk(16'({drive_cfg.decay_rise, drive_cfg.decay_fall}), 16'(e_dec[i[2:0]]));
    end
  endtask : t_fields

  // High impedance from the disable bit and from the drive-off pin
  task automatic t_hiz;
    HOST.wr(ADDR_DECAY, 8'h8f);
    cyc(2);
    chk(16'(outputs_hiz), 16'h1);
    HOST.wr(ADDR_DECAY, 8'h0f);
    cyc(2);
    chk(16'(outputs_hiz), 16'h0);
    drive_off_pin = 1'b1;
    cyc(6);
    chk(16'(outputs_hiz), 16'h1);
    drive_off_pin = 1'b0;
    cyc(6);
    chk(16'(outputs_hiz), 16'h0);
  endtask : t_hiz

  // Direction and step from register or pin; back-to-back register steps
  task automatic t_step;
    dir_pin = 1'b1;
    HOST.wr(ADDR_STEP, 8'ha0);
    cyc(2);
    chk(16'(dir_out), 16'h1);
    HOST.wr(ADDR_STEP, 8'h20);
    cyc(2);
    chk(16'(dir_out), 16'h0);
    HOST.wr(ADDR_STEP, 8'h00);
    cyc(6);
    chk(16'(dir_out), 16'h1);
    n_step = 0;
    HOST.wr(ADDR_STEP, 8'h5a);
    cyc(4);
    chk(16'(n_step), 16'h1);
    rchk(ADDR_STEP, 8'h1a);
    step_pin = 1'b1;
    cyc(6);
    step_pin = 1'b0;
    cyc(6);
    chk(16'(n_step), 16'h1);
    HOST.wr(ADDR_STEP, 8'h50);
    HOST.wr(ADDR_STEP, 8'h50);
    cyc(4);
    chk(16'(n_step), 16'h3);
    HOST.wr(ADDR_STEP, 8'h00);
    n_step = 0;
    step_pin = 1'b1;
    cyc(6);
    step_pin = 1'b0;
    cyc(6);
    chk(16'(n_step), 16'h1);
  endtask : t_step

  // Protection policy, fault clear and warning report
  task automatic t_prot;
    int pm[4] = '{'h30, 'h34, 'h30, 'h32};
    HOST.wr(ADDR_PROT, 8'h0f);
    rchk(ADDR_PROT, 8'h3f);
    chk(16'({open_load_enable, overcurrent_response, thermal_shutdown_response}), 16'h7);
    n_clr = 0;
    HOST.wr(ADDR_PROT, 8'hb0);
    cyc(2);
    chk(16'(n_clr), 16'h1);
    chk(16'({uv_flag, cpuv_flag, fault_pin_n}), 16'h1);
    rchk(ADDR_PROT, 8'h30);
    temp_warning_event = 1'b1;
    cyc(3);
    chk(16'(fault_pin_n), 16'h1);
    HOST.wr(ADDR_PROT, 8'h31);
    cyc(2);
    chk(16'(fault_pin_n), 16'h0);
    temp_warning_event = 1'b0;
    // Latched then automatic, overcurrent then thermal shutdown
    for (int k = 0; k < 4; k++) begin
      HOST.wr(ADDR_PROT, 8'hb0);
      HOST.wr(ADDR_PROT, 8'(pm[k]));
      if (k > 1) overtemp_event = 1'b1;
      else overcurrent_event = 1'b1;
      cyc(2);
      chk(16'(fault_pin_n), 16'h0);
      overcurrent_event = 1'b0;
      overtemp_event = 1'b0;
      cyc(3);
      chk(16'(fault_pin_n), 16'(k % 2));
    end
  endtask : t_prot

  // Lock, wrong unlock code, clear while locked, then unlock
  task automatic t_lock;
    HOST.wr(ADDR_TORQUE, 8'h00);
    HOST.wr(ADDR_PROT, 8'h60);
    HOST.wr(ADDR_TORQUE, 8'h55);
    HOST.wr(ADDR_PROT, 8'h5f);
    rchk(ADDR_TORQUE, 8'h00);
    rchk(ADDR_PROT, 8'h60);
    n_clr = 0;
    HOST.wr(ADDR_PROT, 8'he0);
    cyc(2);
    chk(16'(n_clr), 16'h1);
    HOST.wr(ADDR_PROT, 8'h30);
    HOST.wr(ADDR_TORQUE, 8'h55);
    rchk(ADDR_TORQUE, 8'h55);
  endtask : t_lock

  task automatic stop_test;
    $display("checks_done %0d err_total %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  // Main sequence; reset is held for six cycles
  initial begin
    {drive_off_pin, dir_pin, step_pin} = 3'h0;
    {overcurrent_event, overtemp_event, temp_warning_event} = 3'h0;
    repeat (6) @(posedge clk);
    #1;
    reset_n = 1'b1;
    t_reset;
    t_fields;
    t_hiz;
    t_step;
    t_prot;
    t_lock;
    stop_test;
  end

  // Watchdog against a hang
  initial begin
    #200000;
    err_total++;
    stop_test;
  end
endmodule : sdc_regs_tb
`default_nettype wire
